//--- bench/strap_source.sv
`timescale 1ns/10ps
`default_nettype none
// Board strap resistors: static levels, only sampled by the device during reset
module strap_source (
	input  wire logic [5:0]         level_i,
	output strap_pkg::strap_type    strap_o
);
	import strap_pkg::*;
	assign strap_o = strap_type'(level_i);
endmodule : strap_source
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import strap_pkg::*;
	logic        clk_i = 1'b0;
	logic        nrst_i = 1'b0;
	logic [5:0]  lv = 6'h00;
	strap_type   strap, s;
	logic        an_en = 1'b0, an_tx = 1'b0, an_rx = 1'b0;
	logic        hwrite_i = 1'b0, rd_dphase = 1'b0, hreadyout_o, hresp_o, tx, rx, sa, sm;
	logic [1:0]  htrans_i = 2'h0;
	logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, seed = 32'hd116, r, w;
	logic [15:0] adv;
	logic [15:0] adv_o;
	logic [2:0]  mode_o;
	port1_cfg_type cfg;
	xover_type   xo;
	logic [31:0] exp_q[$];
	int          n_mismatch = 0;
	int          n_tests = 0;

	always #50 clk_i = ~clk_i;

	strap_source strap_source_inst (.level_i(lv), .strap_o(strap));
	port_strap_defaults port_strap_defaults_inst (.clk_i(clk_i), .nrst_i(nrst_i),
		.strap_i(strap), .autoneg_enable_i(an_en), .an_tx_pause_i(an_tx),
		.an_rx_pause_i(an_rx), .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i),
		.hwrite_i(hwrite_i), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata_i),
		.hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.hrdata_o(hrdata_o), .port1_cfg_o(cfg), .autoneg_advertisement_o(adv_o),
		.phy_mode_o(mode_o), .port2_xover_o(xo));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		htrans_i  <= HTRANS_NONSEQ;
		haddr_i   <= {24'h0, a};
		hwrite_i  <= wr;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		htrans_i  <= 2'h0;
		hwdata_i  <= d;
		rd_dphase <= ~wr;
		@(posedge clk_i);
		while (hreadyout_o !== 1'b1) @(posedge clk_i);
		rd_dphase <= 1'b0;
	endtask : bus

	// Direct look at a level output that has stood since an earlier edge
	task automatic chk(input logic [31:0] got, input logic [31:0] e);
		n_tests++;
		if (got !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, e);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd

	// Read data checked where it stands: the data-phase edge
	always @(posedge clk_i) begin
		if (rd_dphase) begin
			n_tests++;
			if (hrdata_o !== exp_q[0]) begin
				n_mismatch++;
				$display("wrong value at %0t: got %h expected %h", $time, hrdata_o, exp_q[0]);
			end
			void'(exp_q.pop_front());
		end
	end

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish

	initial begin
		#2000000;
		n_mismatch++;
		tally_and_finish();
	end

	initial begin
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			r = seed;
			s = strap_type'((i == 0) ? 6'h00 : (i == 1) ? 6'h3f : r[5:0]);
			// Every pass starts from reset so software values must vanish
			@(posedge clk_i);
			nrst_i <= 1'b0;
			lv     <= s;
			an_en  <= r[8];
			an_tx  <= r[9];
			an_rx  <= r[10];
			repeat (8) @(posedge clk_i);
			nrst_i <= 1'b1;
			repeat (2) @(posedge clk_i);
			tx  = s.flow_select ? s.pause_enable : (r[8] & r[9]);
			rx  = s.flow_select ? s.pause_enable : (r[8] & r[10]);
			adv = ADV_BASE_DEFAULT;
			adv[ADV_10FD_BIT] = s.duplex;
			adv[ADV_SYM_PAUSE_BIT] = ~s.flow_select;
			sm = s.auto_xover ? 1'b0 : s.manual_xover;
			w = {25'h0, s.duplex, s.backpressure, {2{s.pause_enable}}, s.flow_select, tx, rx};
			chk({25'h0, cfg}, w);
			chk({16'h0, adv_o}, {16'h0, adv});
			chk({29'h0, mode_o}, {29'h0, s.duplex ? MODE_FULL_DEFAULT : MODE_HALF_DEFAULT});
			chk({30'h0, xo}, {30'h0, s.auto_xover, sm});
			chk({30'h0, hreadyout_o, hresp_o}, 32'h2);
			rd(P1_CTRL_OFS, {27'h0, s.flow_select, {2{s.pause_enable}}, s.backpressure, s.duplex});
			rd(P1_ADV_OFS, {16'h0, adv});
			rd(P1_MODE_OFS, {29'h0, s.duplex ? MODE_FULL_DEFAULT : MODE_HALF_DEFAULT});
			rd(STATUS_OFS, {28'h0, sm, s.auto_xover, rx, tx});
			sa = r[11];
			sm = r[12] & ~sa;
			bus(1'b1, P2_XOVER_OFS, {29'h0, r[12], sa, 1'b1});
			bus(1'b1, STATUS_OFS, 32'hffffffff);
			rd(STATUS_OFS, {28'h0, sm, sa, rx, tx});
			chk({30'h0, xo}, {30'h0, sa, sm});
			w = {27'h0, r[17:13]};
			bus(1'b1, P1_CTRL_OFS, w);
			rd(P1_CTRL_OFS, w);
			// Pause source follows the manual select just written
			tx = w[4] ? w[2] : (r[8] & r[9]);
			rx = w[4] ? w[3] : (r[8] & r[10]);
			chk({25'h0, cfg}, {25'h0, w[0], w[1], w[2], w[3], w[4], tx, rx});
			rd(8'h14, 32'h0);
			$display("strap pattern %h done", s);
		end
		repeat (2) @(posedge clk_i);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire

//--- hdl/port_strap_defaults.sv
`timescale 1ns/10ps
`default_nettype none
module port_strap_defaults (
	input  wire logic                 clk_i,
	input  wire logic                 nrst_i,
	input  wire strap_pkg::strap_type strap_i,
	input  wire logic                 autoneg_enable_i,
	input  wire logic                 an_tx_pause_i,
	input  wire logic                 an_rx_pause_i,
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	output logic [31:0]               hrdata_o,
	output strap_pkg::port1_cfg_type  port1_cfg_o,
	output logic [15:0]               autoneg_advertisement_o,
	output logic [2:0]                phy_mode_o,
	output strap_pkg::xover_type      port2_xover_o
);
	import strap_pkg::*;

	state_type st;
	state_type st_nxt;
	xover_type xo_w;
	logic      accept;

	function automatic logic [31:0] read_word(input state_type s, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0;
		case (a)
			P1_CTRL_OFS: begin
				w[CTRL_DUPLEX_BIT] = s.p1.duplex;
				w[CTRL_BP_BIT]     = s.p1.backpressure;
				w[CTRL_TXP_BIT]    = s.p1.tx_pause_en;
				w[CTRL_RXP_BIT]    = s.p1.rx_pause_en;
				w[CTRL_MANUAL_BIT] = s.p1.manual_select;
			end
			P1_ADV_OFS: w[ADV_W-1:0] = s.adv;
			P1_MODE_OFS: w[MODE_W-1:0] = s.mode;
			P2_XOVER_OFS: begin
				w[XOVER_OVR_BIT]  = s.ovr;
				w[XOVER_AUTO_BIT] = s.sw_auto;
				w[XOVER_MDIX_BIT] = s.sw_mdix;
			end
			STATUS_OFS: begin
				w[STAT_TXP_BIT]  = s.p1.tx_pause_eff;
				w[STAT_RXP_BIT]  = s.p1.rx_pause_eff;
				w[STAT_AUTO_BIT] = s.xo.auto_en;
				w[STAT_MDIX_BIT] = s.xo.mdix;
			end
			default: w = 32'h0;
		endcase
		return w;
	endfunction : read_word

	xover_select u_xover (
		.override_i   (st.ovr),
		.strap_auto_i (st.strap_auto),
		.strap_mdix_i (st.strap_mdix),
		.sw_auto_i    (st.sw_auto),
		.sw_mdix_i    (st.sw_mdix),
		.xover_o      (xo_w)
	);

	// Zero-wait slave: every NONSEQ address phase is taken on the edge it is seen
	assign accept = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

	always_comb begin
		st_nxt = st;
		// Data phase of a write; only whole-word writes alter anything
		if (st.wr_pend) begin
			case (st.wr_addr)
				P1_CTRL_OFS: begin
					st_nxt.p1.duplex        = hwdata_i[CTRL_DUPLEX_BIT];
					st_nxt.p1.backpressure  = hwdata_i[CTRL_BP_BIT];
					st_nxt.p1.tx_pause_en   = hwdata_i[CTRL_TXP_BIT];
					st_nxt.p1.rx_pause_en   = hwdata_i[CTRL_RXP_BIT];
					st_nxt.p1.manual_select = hwdata_i[CTRL_MANUAL_BIT];
				end
				P1_ADV_OFS: st_nxt.adv = hwdata_i[ADV_W-1:0];
				P1_MODE_OFS: st_nxt.mode = hwdata_i[MODE_W-1:0];
				P2_XOVER_OFS: begin
					st_nxt.ovr     = hwdata_i[XOVER_OVR_BIT];
					st_nxt.sw_auto = hwdata_i[XOVER_AUTO_BIT];
					st_nxt.sw_mdix = hwdata_i[XOVER_MDIX_BIT];
				end
				default: ;
			endcase
		end
		st_nxt.wr_pend = 1'b0;
		if (accept) begin
			st_nxt.wr_pend = hwrite_i && (hsize_i == HSIZE_WORD);
			st_nxt.wr_addr = haddr_i[ADDR_W-1:0];
			// Read sees a write finishing in the same cycle
			if (!hwrite_i) begin
				st_nxt.rdata = read_word(st_nxt, haddr_i[ADDR_W-1:0]);
			end
		end
		// Flow-control source selection
		if (st.p1.manual_select) begin
			st_nxt.p1.tx_pause_eff = st.p1.tx_pause_en;
			st_nxt.p1.rx_pause_eff = st.p1.rx_pause_en;
		end else if (autoneg_enable_i) begin
			st_nxt.p1.tx_pause_eff = an_tx_pause_i;
			st_nxt.p1.rx_pause_eff = an_rx_pause_i;
		end else begin
			st_nxt.p1.tx_pause_eff = 1'b0;
			st_nxt.p1.rx_pause_eff = 1'b0;
		end
		st_nxt.xo = xo_w;
		// Straps are sampled on every reset cycle; last one before release wins
		if (!nrst_i) begin
			st_nxt.p1.duplex        = strap_i.duplex;
			st_nxt.p1.backpressure  = strap_i.backpressure;
			st_nxt.p1.tx_pause_en   = strap_i.pause_enable;
			st_nxt.p1.rx_pause_en   = strap_i.pause_enable;
			st_nxt.p1.manual_select = strap_i.flow_select;
			st_nxt.p1.tx_pause_eff  = 1'b0;
			st_nxt.p1.rx_pause_eff  = 1'b0;
			st_nxt.adv = ADV_BASE_DEFAULT;
			st_nxt.adv[ADV_10FD_BIT] = strap_i.duplex;
			st_nxt.adv[ADV_SYM_PAUSE_BIT] = !strap_i.flow_select;
			st_nxt.mode = strap_i.duplex ? MODE_FULL_DEFAULT : MODE_HALF_DEFAULT;
			st_nxt.ovr        = 1'b0;
			st_nxt.sw_auto    = 1'b0;
			st_nxt.sw_mdix    = 1'b0;
			st_nxt.strap_auto = strap_i.auto_xover;
			st_nxt.strap_mdix = strap_i.manual_xover;
			st_nxt.xo         = '0;
			st_nxt.wr_pend    = 1'b0;
			st_nxt.wr_addr    = 8'h00;
			st_nxt.rdata      = 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		st <= st_nxt;
	end

	assign hreadyout_o             = 1'b1;
	assign hresp_o                 = 1'b0;
	assign hrdata_o                = st.rdata;
	assign port1_cfg_o             = st.p1;
	assign autoneg_advertisement_o = st.adv;
	assign phy_mode_o              = st.mode;
	assign port2_xover_o           = st.xo;

	// Checking helpers: strap value held over the last reset cycle
	strap_type strap_q;
	logic      just_rel;
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			strap_q <= strap_i;
		end
		just_rel <= !nrst_i;
	end

	sequence s_ctrl_write;
		accept && hwrite_i && hsize_i == HSIZE_WORD && haddr_i[ADDR_W-1:0] == P1_CTRL_OFS
		##1 1'b1;
	endsequence

	sequence s_released;
		just_rel && nrst_i;
	endsequence

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	a_duplex_load: assert property (s_released |-> port1_cfg_o.duplex == strap_q.duplex)
		else $error("duplex default does not match strap");
	a_adv_mode_load: assert property (s_released |->
		autoneg_advertisement_o[ADV_10FD_BIT] == strap_q.duplex &&
		phy_mode_o == (strap_q.duplex ? MODE_FULL_DEFAULT : MODE_HALF_DEFAULT))
		else $error("advertisement or mode default wrong");
	a_bp_load: assert property (s_released |-> port1_cfg_o.backpressure == strap_q.backpressure)
		else $error("backpressure default wrong");
	a_pause_load: assert property (s_released |->
		port1_cfg_o.tx_pause_en == strap_q.pause_enable &&
		port1_cfg_o.rx_pause_en == strap_q.pause_enable)
		else $error("pause enable defaults wrong");
	a_sym_pause_load: assert property (s_released |->
		autoneg_advertisement_o[ADV_SYM_PAUSE_BIT] == !strap_q.flow_select &&
		port1_cfg_o.manual_select == strap_q.flow_select)
		else $error("symmetric pause default wrong");
	// Release edge still loads reset values, so derived outputs lag one cycle
	a_flow_auto_src: assert property (nrst_i && !st.p1.manual_select && autoneg_enable_i |=>
		port1_cfg_o.tx_pause_eff == $past(an_tx_pause_i) &&
		port1_cfg_o.rx_pause_eff == $past(an_rx_pause_i))
		else $error("autoneg flow result not applied");
	a_flow_manual_src: assert property (nrst_i && st.p1.manual_select |=>
		port1_cfg_o.tx_pause_eff == $past(st.p1.tx_pause_en) &&
		port1_cfg_o.rx_pause_eff == $past(st.p1.rx_pause_en))
		else $error("manual pause enables not applied");
	a_xover_strap: assert property (nrst_i && !st.ovr |=>
		port2_xover_o.auto_en == $past(st.strap_auto))
		else $error("auto crossover not following strap");
	a_xover_ignore: assert property (nrst_i && st.ovr |=>
		port2_xover_o.auto_en == $past(st.sw_auto))
		else $error("strap not ignored under override");
	a_xover_force: assert property (nrst_i && !st.ovr && !st.strap_auto |=>
		!port2_xover_o.auto_en && port2_xover_o.mdix == $past(st.strap_mdix))
		else $error("manual crossover not forced");
	a_sw_override: assert property (s_ctrl_write |=>
		port1_cfg_o.duplex == $past(hwdata_i[CTRL_DUPLEX_BIT]) &&
		port1_cfg_o.manual_select == $past(hwdata_i[CTRL_MANUAL_BIT]))
		else $error("software write did not override default");

endmodule : port_strap_defaults
`default_nettype wire

//--- hdl/strap_pkg.sv
package strap_pkg;

	// Register byte offsets
	localparam int unsigned ADDR_W        = 8;
	localparam logic [7:0]  P1_CTRL_OFS   = 8'h00;
	localparam logic [7:0]  P1_ADV_OFS    = 8'h04;
	localparam logic [7:0]  P1_MODE_OFS   = 8'h08;
	localparam logic [7:0]  P2_XOVER_OFS  = 8'h0c;
	localparam logic [7:0]  STATUS_OFS    = 8'h10;

	// Port 1 control fields
	localparam int unsigned CTRL_DUPLEX_BIT = 0;
	localparam int unsigned CTRL_BP_BIT     = 1;
	localparam int unsigned CTRL_TXP_BIT    = 2;
	localparam int unsigned CTRL_RXP_BIT    = 3;
	localparam int unsigned CTRL_MANUAL_BIT = 4;

	// Advertisement fields
	localparam int unsigned ADV_W             = 16;
	localparam int unsigned ADV_10FD_BIT      = 6;
	localparam int unsigned ADV_SYM_PAUSE_BIT = 10;
	localparam logic [15:0] ADV_BASE_DEFAULT  = 16'h0000;

	// Operating-mode field
	localparam int unsigned MODE_W            = 3;
	localparam logic [2:0]  MODE_HALF_DEFAULT = 3'h0;
	localparam logic [2:0]  MODE_FULL_DEFAULT = 3'h1;

	// Port 2 crossover fields
	localparam int unsigned XOVER_OVR_BIT  = 0;
	localparam int unsigned XOVER_AUTO_BIT = 1;
	localparam int unsigned XOVER_MDIX_BIT = 2;

	// Status fields
	localparam int unsigned STAT_TXP_BIT  = 0;
	localparam int unsigned STAT_RXP_BIT  = 1;
	localparam int unsigned STAT_AUTO_BIT = 2;
	localparam int unsigned STAT_MDIX_BIT = 3;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef struct packed {
		logic duplex;
		logic backpressure;
		logic pause_enable;
		logic flow_select;
		logic auto_xover;
		logic manual_xover;
	} strap_type;

	typedef struct packed {
		logic duplex;
		logic backpressure;
		logic tx_pause_en;
		logic rx_pause_en;
		logic manual_select;
		logic tx_pause_eff;
		logic rx_pause_eff;
	} port1_cfg_type;

	typedef struct packed {
		logic auto_en;
		logic mdix;
	} xover_type;

	typedef struct packed {
		port1_cfg_type     p1;
		logic [15:0]       adv;
		logic [2:0]        mode;
		logic              ovr;
		logic              sw_auto;
		logic              sw_mdix;
		logic              strap_auto;
		logic              strap_mdix;
		xover_type         xo;
		logic              wr_pend;
		logic [7:0]        wr_addr;
		logic [31:0]       rdata;
	} state_type;

endpackage : strap_pkg

//--- hdl/xover_select.sv
`timescale 1ns/10ps
`default_nettype none
module xover_select (
	input  wire logic                 override_i,
	input  wire logic                 strap_auto_i,
	input  wire logic                 strap_mdix_i,
	input  wire logic                 sw_auto_i,
	input  wire logic                 sw_mdix_i,
	output strap_pkg::xover_type      xover_o
);
	import strap_pkg::*;

	always_comb begin
		if (override_i) begin
			// Straps have no say once software owns crossover
			xover_o.auto_en = sw_auto_i;
			xover_o.mdix    = sw_auto_i ? 1'b0 : sw_mdix_i;
		end else begin
			xover_o.auto_en = strap_auto_i;
			xover_o.mdix    = strap_auto_i ? 1'b0 : strap_mdix_i;
		end
	end

endmodule : xover_select
`default_nettype wire
